// [strap_board_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Board strap resistors sharing pins with LED and data drivers
// ----------------------------------------
module strap_board_model (
  input wire logic clk,
  input wire logic [11:0] cfg,
  input wire logic rogue,
  input wire logic led_active,
  output logic [11:0] pins
);
  logic [11:0] legal;
  logic [11:0] churn = 12'h5a5;

  // Rogue lets a scenario strap what a careful board never would
  always_comb begin
    legal = cfg;
    if (!rogue) begin
      legal[10] = 1'b0;
      if (cfg[7:6] == 2'h1) legal[1] = 1'b1;
      if (!cfg[5]) legal[3] = 1'b1;
    end
  end

  // Once the pins act as outputs they change every cycle
  always @(posedge clk) churn <= churn + 12'h3a7;

  assign pins = led_active ? churn : legal;
endmodule

// [strap_config_latch.sv]
`timescale 1ns/1ps
`include "strap_consts.svh"

// How it works
// - Straps are sampled at the end of power-up or software reset.
// - Straps are also latched on power-down exit and on reset release.
// - Forward strap 0 holds forwarding until software start bit; 1 forwards at once.
// - In-band management strap 0 enables, 1 disables (default).
// - Role 0: PHY side in MII, drive RMII reference clock, no in-band status.
// - Role 1: MAC side in MII, accept reference clock, in-band status on.
// - Speed strap 0 selects gigabit, 1 selects 100 megabit.
// - Interface type 00 MII, 01 RMII, 11 RGMII, 10 reserved.
// - Management 00 MDIO, 01 I2C, 1x SPI.
// - PHY code 01 autoneg with EEE; 10/11 forced 100 full, MDI-X/MDI.
// - Test strap 0 normal, 1 vendor test mode; board keeps it 0.
// - Emission filter strap 0 off, 1 on.
module strap_config_latch
  import strap_pkg::*;
#(
  parameter int SETTLE_CYCLES = `STRAP_SETTLE_CYCLES
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SW_RESET,
  input wire logic PWRDN_EXIT,
  input wire logic START_SWITCH,
  input wire logic STRAP_FORWARD_ENABLE,
  input wire logic STRAP_INBAND_MGMT,
  input wire logic STRAP_HOST_PORT_ROLE,
  input wire logic STRAP_HOST_PORT_SPEED,
  input wire logic STRAP_IF_TYPE_HI,
  input wire logic STRAP_IF_TYPE_LO,
  input wire logic STRAP_MGMT_SEL_HI,
  input wire logic STRAP_MGMT_SEL_LO,
  input wire logic STRAP_PHY_CFG_HI,
  input wire logic STRAP_PHY_CFG_LO,
  input wire logic STRAP_TEST_MODE,
  input wire logic STRAP_EMISSION_FILTER,
  output logic CONFIG_VALID,
  output logic FORWARD_ENABLE,
  output logic INBAND_MANAGEMENT,
  output logic HOST_PHY_SIDE,
  output logic REF_CLOCK_OUTPUT_EN,
  output logic REF_CLOCK_INPUT_SEL,
  output logic INBAND_LINK_STATUS,
  output logic HOST_GIGABIT,
  output host_if_e HOST_IF_TYPE,
  output logic HOST_IF_RESERVED,
  output mgmt_if_e MGMT_IF,
  output logic MDIO_MANAGEMENT_IF,
  output logic PHY_AUTONEG_EN,
  output logic PHY_EEE_EN,
  output logic PHY_FORCE_100FD,
  output logic PHY_MDIX,
  output logic PHY_CFG_RESERVED,
  output logic TEST_MODE,
  output logic EMISSION_FILTER
);

  // ----------------------------------------
  // Pin capture
  // ----------------------------------------
  logic [`STRAP_WIDTH-1:0] pins;
  logic [`STRAP_WIDTH-1:0] pins_stable;
  logic [`STRAP_WIDTH-1:0] strap_reg;
  logic settle_start;
  logic settle_done;
  logic por_pending_reg;
  logic sw_reset_d_reg;
  logic pwrdn_d_reg;
  logic start_bit_reg;
  logic valid_reg;

  assign pins = {STRAP_EMISSION_FILTER, STRAP_TEST_MODE, STRAP_PHY_CFG_HI, STRAP_PHY_CFG_LO,
                 STRAP_MGMT_SEL_HI, STRAP_MGMT_SEL_LO, STRAP_IF_TYPE_HI, STRAP_IF_TYPE_LO,
                 STRAP_HOST_PORT_SPEED, STRAP_HOST_PORT_ROLE, STRAP_INBAND_MGMT,
                 STRAP_FORWARD_ENABLE};

  strap_sync #(
    .WIDTH(`STRAP_WIDTH)
  ) u_sync (
    .CLK(CLK),
    .NRST(NRST),
    .pin_in(pins),
    .pin_stable(pins_stable)
  );

  // ----------------------------------------
  // Sampling events
  // ----------------------------------------
  // Reset release arms a pending sample; the settle wait lets the
  // synchroniser flush its reset image before the pins are trusted.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      por_pending_reg <= 1'b1;
      sw_reset_d_reg <= 1'b0;
      pwrdn_d_reg <= 1'b0;
    end else begin
      por_pending_reg <= 1'b0;
      sw_reset_d_reg <= SW_RESET;
      pwrdn_d_reg <= PWRDN_EXIT;
    end
  end

  // Software reset and power-down exit sample at the falling edge of their request
  assign settle_start = por_pending_reg | (sw_reset_d_reg & ~SW_RESET) |
                        (pwrdn_d_reg & ~PWRDN_EXIT);

  // A reset-release sample must wait out the synchroniser refill, so the
  // settle count never drops below its depth whatever the parameter says
  localparam int SYNC_REFILL = 3;
  localparam int SETTLE_USED = (SETTLE_CYCLES < SYNC_REFILL) ? SYNC_REFILL : SETTLE_CYCLES;

  strap_settle #(
    .CYCLES(SETTLE_USED)
  ) u_settle (
    .CLK(CLK),
    .NRST(NRST),
    .start(settle_start),
    .done(settle_done)
  );

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      strap_reg <= `STRAP_RESET_VALUE;
      valid_reg <= 1'b0;
    end else if (settle_done) begin
      strap_reg <= pins_stable;
      // A start in the same cycle leaves the new sample pending again
      valid_reg <= ~settle_start;
    end else if (settle_start) begin
      valid_reg <= 1'b0;
    end
    // Held otherwise, so later LED or data activity on the pins is ignored
  end

  // Software start bit lives only until the next sampling event
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      start_bit_reg <= 1'b0;
    end else if (settle_start) begin
      start_bit_reg <= 1'b0;
    end else if (START_SWITCH) begin
      start_bit_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic role;
  logic [1:0] if_code;
  logic [1:0] mgmt_code;
  logic [1:0] phy_code;

  assign role = strap_reg[`BIT_HOST_PORT_ROLE];
  assign if_code = {strap_reg[`BIT_IF_TYPE_HI], strap_reg[`BIT_IF_TYPE_LO]};
  assign mgmt_code = {strap_reg[`BIT_MGMT_SEL_HI], strap_reg[`BIT_MGMT_SEL_LO]};
  assign phy_code = {strap_reg[`BIT_PHY_CFG_HI], strap_reg[`BIT_PHY_CFG_LO]};

  always_comb begin
    case (if_code)
      2'h0: HOST_IF_TYPE = IF_MII;
      2'h1: HOST_IF_TYPE = IF_RMII;
      2'h3: HOST_IF_TYPE = IF_RGMII;
      default: HOST_IF_TYPE = IF_RESERVED;
    endcase
  end

  always_comb begin
    case (mgmt_code)
      2'h0: MGMT_IF = MGMT_MDIO;
      2'h1: MGMT_IF = MGMT_I2C;
      default: MGMT_IF = MGMT_SPI;
    endcase
  end

  // Forwarding waits for valid straps so no packet passes on the reset image
  assign CONFIG_VALID = valid_reg;
  assign FORWARD_ENABLE = valid_reg & (strap_reg[`BIT_FORWARD_ENABLE] | start_bit_reg);
  // Strap is active low; the board is trusted not to pair it with I2C
  assign INBAND_MANAGEMENT = ~strap_reg[`BIT_INBAND_MGMT];
  assign HOST_PHY_SIDE = (HOST_IF_TYPE == IF_MII) & ~role;
  assign REF_CLOCK_OUTPUT_EN = (HOST_IF_TYPE == IF_RMII) & ~role;
  assign REF_CLOCK_INPUT_SEL = (HOST_IF_TYPE == IF_RMII) & role;
  assign INBAND_LINK_STATUS = (HOST_IF_TYPE == IF_RGMII) & role;
  // Speed pin relies on the board keeping 100M for MII/RMII
  assign HOST_GIGABIT = ~strap_reg[`BIT_HOST_PORT_SPEED];
  assign HOST_IF_RESERVED = (HOST_IF_TYPE == IF_RESERVED);
  assign MDIO_MANAGEMENT_IF = (MGMT_IF == MGMT_MDIO);
  assign PHY_AUTONEG_EN = (phy_code == 2'h1);
  assign PHY_EEE_EN = (phy_code == 2'h1);
  assign PHY_FORCE_100FD = phy_code[1];
  assign PHY_MDIX = (phy_code == 2'h2);
  assign PHY_CFG_RESERVED = (phy_code == 2'h0);
  assign TEST_MODE = strap_reg[`BIT_TEST_MODE];
  assign EMISSION_FILTER = strap_reg[`BIT_EMISSION_FILTER];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sample_after_settle_a: assert property (@(posedge CLK) disable iff (!NRST)
    settle_done |=> strap_reg == $past(pins_stable))
    else $error("strap image not taken on settle done");

  resample_on_start_a: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(SW_RESET) |=> !valid_reg)
    else $error("software reset exit did not restart sampling");

  hold_between_a: assert property (@(posedge CLK) disable iff (!NRST)
    !settle_done |=> $stable(strap_reg))
    else $error("strap image changed without a sample");

  forward_gate_a: assert property (@(posedge CLK) disable iff (!NRST)
    valid_reg && !strap_reg[`BIT_FORWARD_ENABLE] && !start_bit_reg |-> !FORWARD_ENABLE)
    else $error("forwarding without start bit");

  forward_start_a: assert property (@(posedge CLK) disable iff (!NRST)
    START_SWITCH && valid_reg && !settle_start ##1 valid_reg |-> FORWARD_ENABLE)
    else $error("start bit did not enable forwarding");

  inband_polarity_a: assert property (@(posedge CLK) disable iff (!NRST)
    INBAND_MANAGEMENT != strap_reg[`BIT_INBAND_MGMT])
    else $error("in-band management polarity wrong");

  refclk_role_a: assert property (@(posedge CLK) disable iff (!NRST)
    !(REF_CLOCK_OUTPUT_EN && REF_CLOCK_INPUT_SEL))
    else $error("reference clock both driven and accepted");

  phy_force_a: assert property (@(posedge CLK) disable iff (!NRST)
    PHY_FORCE_100FD |-> !PHY_AUTONEG_EN && (PHY_MDIX == !strap_reg[`BIT_PHY_CFG_LO]))
    else $error("forced PHY mode decode wrong");

  mgmt_spi_a: assert property (@(posedge CLK) disable iff (!NRST)
    strap_reg[`BIT_MGMT_SEL_HI] |-> MGMT_IF == MGMT_SPI)
    else $error("SPI not selected for upper code");

  valid_on_done_a: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(valid_reg) |-> $past(settle_done))
    else $error("config valid rose without a finished sample");

  pwrdn_restart_a: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(PWRDN_EXIT) |=> !valid_reg)
    else $error("power-down exit did not restart sampling");

  start_clear_a: assert property (@(posedge CLK) disable iff (!NRST)
    settle_start |=> !start_bit_reg)
    else $error("start bit survived a new sample");

  forward_wait_a: assert property (@(posedge CLK) disable iff (!NRST)
    !valid_reg |-> !FORWARD_ENABLE)
    else $error("forwarding before straps were valid");

  mii_side_a: assert property (@(posedge CLK) disable iff (!NRST)
    HOST_IF_TYPE == IF_MII |-> HOST_PHY_SIDE == !role)
    else $error("MII side decode wrong");

  rmii_clock_out_a: assert property (@(posedge CLK) disable iff (!NRST)
    HOST_IF_TYPE == IF_RMII && !role |-> REF_CLOCK_OUTPUT_EN)
    else $error("reference clock not driven in clock mode");

  rmii_clock_in_a: assert property (@(posedge CLK) disable iff (!NRST)
    HOST_IF_TYPE == IF_RMII && role |-> REF_CLOCK_INPUT_SEL)
    else $error("reference clock not accepted in normal mode");

  rgmii_status_a: assert property (@(posedge CLK) disable iff (!NRST)
    HOST_IF_TYPE == IF_RGMII |-> INBAND_LINK_STATUS == role)
    else $error("in-band link status decode wrong");

  speed_select_a: assert property (@(posedge CLK) disable iff (!NRST)
    HOST_GIGABIT != strap_reg[`BIT_HOST_PORT_SPEED])
    else $error("host speed decode wrong");

  if_reserved_a: assert property (@(posedge CLK) disable iff (!NRST)
    HOST_IF_RESERVED == (if_code == 2'h2))
    else $error("reserved interface code not flagged");

  mgmt_mdio_a: assert property (@(posedge CLK) disable iff (!NRST)
    MDIO_MANAGEMENT_IF == (mgmt_code == 2'h0))
    else $error("MDIO management decode wrong");

  phy_autoneg_a: assert property (@(posedge CLK) disable iff (!NRST)
    phy_code == 2'h1 |-> PHY_AUTONEG_EN && PHY_EEE_EN && !PHY_FORCE_100FD)
    else $error("auto-negotiation decode wrong");

  phy_reserved_a: assert property (@(posedge CLK) disable iff (!NRST)
    PHY_CFG_RESERVED == (phy_code == 2'h0))
    else $error("reserved PHY code not flagged");

  test_mode_a: assert property (@(posedge CLK) disable iff (!NRST)
    TEST_MODE == strap_reg[`BIT_TEST_MODE])
    else $error("test mode decode wrong");

  emission_filter_a: assert property (@(posedge CLK) disable iff (!NRST)
    EMISSION_FILTER == strap_reg[`BIT_EMISSION_FILTER])
    else $error("emission filter decode wrong");

endmodule

// [strap_config_latch_test.sv]
`timescale 1ns/1ps

module strap_config_latch_test;
  import strap_pkg::*;
  logic clk, nrst, sw_reset, pwrdn_exit, start_sw, rogue, led_active, chk_req, prev_v;
  logic [11:0] cfg, c, last_pins;
  logic [20:0] exp_v;
  logic [20:0] exp_q[$];
  wire [11:0] pins;
  wire [20:0] got;
  int err_total, samples_checked, seed;

  `define CHECK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value at %0t ns: got %h expected %h", $time, (a), (e)); end end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  strap_board_model strap_board_model_inst (.clk(clk), .cfg(cfg), .rogue(rogue),
    .led_active(led_active), .pins(pins));

  strap_config_latch #(.SETTLE_CYCLES(2)) strap_config_latch_inst (
    .CLK(clk), .NRST(nrst), .SW_RESET(sw_reset), .PWRDN_EXIT(pwrdn_exit),
    .START_SWITCH(start_sw), .STRAP_FORWARD_ENABLE(pins[0]), .STRAP_INBAND_MGMT(pins[1]),
    .STRAP_HOST_PORT_ROLE(pins[2]), .STRAP_HOST_PORT_SPEED(pins[3]),
    .STRAP_IF_TYPE_LO(pins[4]), .STRAP_IF_TYPE_HI(pins[5]), .STRAP_MGMT_SEL_LO(pins[6]),
    .STRAP_MGMT_SEL_HI(pins[7]), .STRAP_PHY_CFG_LO(pins[8]), .STRAP_PHY_CFG_HI(pins[9]),
    .STRAP_TEST_MODE(pins[10]), .STRAP_EMISSION_FILTER(pins[11]),
    .CONFIG_VALID(got[20]), .FORWARD_ENABLE(got[19]), .INBAND_MANAGEMENT(got[18]),
    .HOST_PHY_SIDE(got[17]), .REF_CLOCK_OUTPUT_EN(got[16]), .REF_CLOCK_INPUT_SEL(got[15]),
    .INBAND_LINK_STATUS(got[14]), .HOST_GIGABIT(got[13]), .HOST_IF_TYPE(got[12:11]),
    .HOST_IF_RESERVED(got[10]), .MGMT_IF(got[9:8]), .MDIO_MANAGEMENT_IF(got[7]),
    .PHY_AUTONEG_EN(got[6]), .PHY_EEE_EN(got[5]), .PHY_FORCE_100FD(got[4]),
    .PHY_MDIX(got[3]), .PHY_CFG_RESERVED(got[2]), .TEST_MODE(got[1]),
    .EMISSION_FILTER(got[0]));

  // ----------------------------------------
  // Expected decode of one strap image
  // ----------------------------------------
  function automatic logic [20:0] expect_of(input logic [11:0] s, input logic st,
                                            input logic v);
    logic [1:0] it, ms, pc;
    it = s[5:4];
    ms = s[7:6];
    pc = s[9:8];
    return {v, v & (s[0] | st), ~s[1], it == 2'h0 && !s[2], it == 2'h1 && !s[2],
      it == 2'h1 && s[2], it == 2'h3 && s[2], ~s[3], it, it == 2'h2,
      ms[1] ? 2'h2 : ms, ms == 2'h0, pc == 2'h1, pc == 2'h1, pc[1], pc == 2'h2,
      pc == 2'h0, s[10], s[11]};
  endfunction

  task automatic close_out();
    $display("checked %0d values, %0d wrong", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_valid(input logic lvl);
    int n;
    n = 0;
    while (got[20] !== lvl && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (got[20] !== lvl) begin
      err_total++;
      close_out();
    end
  endtask

  // Pins get four cycles to pass the input synchronizer before any sample
  task automatic settle_pins(input logic [11:0] s, input logic rg);
    @(negedge clk);
    cfg = s;
    rogue = rg;
    repeat (4) @(negedge clk);
  endtask

  // Kind 0 software reset, 1 power-down exit, 2 reset pin; dbl restarts mid-settle
  task automatic sample(input int kind, input logic dbl);
    last_pins = pins;
    exp_q.push_back(expect_of(last_pins, 1'b0, 1'b1));
    repeat (dbl ? 2 : 1) begin
      @(negedge clk);
      if (kind == 0) sw_reset = 1'b1;
      else if (kind == 1) pwrdn_exit = 1'b1;
      else nrst = 1'b0;
      @(negedge clk);
      sw_reset = 1'b0;
      pwrdn_exit = 1'b0;
      nrst = 1'b1;
    end
    wait_valid(1'b0);
    wait_valid(1'b1);
    @(negedge clk);
  endtask

  task automatic note_now(input logic st);
    exp_q.push_back(expect_of(last_pins, st, 1'b1));
    @(negedge clk);
    chk_req = 1'b1;
    @(negedge clk);
    chk_req = 1'b0;
  endtask

  // ----------------------------------------
  // Monitor: a fresh sample or a requested look takes the oldest note
  // ----------------------------------------
  always @(posedge clk) begin
    #20;
    if ((got[20] === 1'b1 && prev_v !== 1'b1) || chk_req) begin
      exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 21'h0;
      `CHECK(got, exp_v)
    end
    prev_v = got[20];
  end

  initial begin
    nrst = 1'b0;
    {sw_reset, pwrdn_exit, start_sw, rogue, led_active, chk_req, prev_v} = 7'h0;
    cfg = 12'h10f;
    seed = 32'h8dde2954;
    repeat (12) @(negedge clk);
    `CHECK(got[20:19], 2'h0)
    sample(2, 1'b0);
    $display("test power-up defaults done");
    for (int k = 0; k < 16; k++) begin
      c = 12'($random(seed));
      c[5:4] = k[1:0];
      c[7:6] = k[3:2];
      c[9:8] = k[1:0] ^ k[3:2];
      c[2] = k[0] ^ k[3];
      c[1] = k[1];
      c[3] = k[1];
      c[10] = k[0];
      settle_pins(c, k[2] & k[0]);
      sample(k % 3, k[2]);
    end
    $display("test strap codes done");
    led_active = 1'b1;
    repeat (20) @(negedge clk);
    note_now(1'b0);
    led_active = 1'b0;
    $display("test pin activity done");
    settle_pins(12'h10e, 1'b0);
    sample(0, 1'b0);
    start_sw = 1'b1;
    @(negedge clk);
    start_sw = 1'b0;
    repeat (2) @(negedge clk);
    note_now(1'b1);
    sample(1, 1'b0);
    $display("test start bit done");
    close_out();
  end
endmodule

// [strap_consts.svh]
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH

// ----------------------------------------
// Strap vector bit positions
// ----------------------------------------
`define STRAP_WIDTH 12
`define BIT_FORWARD_ENABLE 0
`define BIT_INBAND_MGMT 1
`define BIT_HOST_PORT_ROLE 2
`define BIT_HOST_PORT_SPEED 3
`define BIT_IF_TYPE_LO 4
`define BIT_IF_TYPE_HI 5
`define BIT_MGMT_SEL_LO 6
`define BIT_MGMT_SEL_HI 7
`define BIT_PHY_CFG_LO 8
`define BIT_PHY_CFG_HI 9
`define BIT_TEST_MODE 10
`define BIT_EMISSION_FILTER 11

// ----------------------------------------
// Default strap image held before the first sample
// ----------------------------------------
`define STRAP_RESET_VALUE 12'h10f

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define STRAP_SETTLE_NS 1000
`define STRAP_SETTLE_CYCLES ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [strap_pkg.sv]
package strap_pkg;

  typedef enum logic [1:0] {
    IF_MII,
    IF_RMII,
    IF_RESERVED,
    IF_RGMII
  } host_if_e;

  typedef enum logic [1:0] {
    MGMT_MDIO,
    MGMT_I2C,
    MGMT_SPI
  } mgmt_if_e;

  typedef enum logic [1:0] {
    PHY_RESERVED,
    PHY_AUTONEG_EEE,
    PHY_FORCE_MDIX,
    PHY_FORCE_MDI
  } phy_mode_e;

endpackage

// [strap_settle.sv]
`timescale 1ns/1ps
`include "strap_consts.svh"

module strap_settle #(
  parameter int CYCLES = 10
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic start,
  output logic done
);

  logic [15:0] count_reg;
  logic busy_reg;

  // ----------------------------------------
  // Waits for strap pins to settle, then pulses done once
  // ----------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      count_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_reg <= 16'(CYCLES - 1);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (count_reg == 16'h0000) begin
          busy_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - 16'h0001;
        end
      end
    end
  end

endmodule

// [strap_sync.sv]
`timescale 1ns/1ps
`include "strap_consts.svh"

module strap_sync #(
  parameter int WIDTH = 12
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_stable
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // ----------------------------------------
  // Three-stage capture of the pins
  // ----------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s1_reg <= WIDTH'(`STRAP_RESET_VALUE);
      s2_reg <= WIDTH'(`STRAP_RESET_VALUE);
      s3_reg <= WIDTH'(`STRAP_RESET_VALUE);
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pin_stable <= WIDTH'(`STRAP_RESET_VALUE);
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pin_stable[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule
